/* File: verilog/ctw_pkg.sv */
package ctw_pkg;

  // ----------------------------------------------------------------
  // reset values and cycle-counter constants
  // ----------------------------------------------------------------
  localparam logic [7:0] CTW_ACC_RST = 8'h00;
  localparam logic [7:0] CTW_X_RST   = 8'h00;
  localparam logic [7:0] CTW_Y_RST   = 8'h00;
  localparam logic [7:0] CTW_SP_RST  = 8'h00;
  localparam logic [3:0] CTW_REM_RST = 4'h0;
  localparam logic [3:0] CTW_REM_END = 4'h1;
  localparam logic [3:0] CTW_CYC_ONE = 4'h1;

  // ----------------------------------------------------------------
  // operation classes and addressing modes
  // ----------------------------------------------------------------
  typedef enum logic [4:0] {
    OP_NONE               = 5'h00, OP_LOAD_ACCUM         = 5'h01,
    OP_LOAD_ACCUM_XI      = 5'h02, OP_LOAD_MEM_IMMEDIATE = 5'h03,
    OP_LOAD_INDEX_X       = 5'h04, OP_LOAD_INDEX_Y       = 5'h05,
    OP_STORE_ACCUM        = 5'h06, OP_STORE_ACCUM_XI     = 5'h07,
    OP_STORE_INDEX_X      = 5'h08, OP_STORE_INDEX_Y      = 5'h09,
    OP_COPY_ACCUM_TO_X    = 5'h0A, OP_COPY_ACCUM_TO_Y    = 5'h0B,
    OP_COPY_STACKPTR_TO_X = 5'h0C, OP_COPY_X_TO_ACCUM    = 5'h0D,
    OP_COPY_X_TO_STACKPTR = 5'h0E, OP_COPY_Y_TO_ACCUM    = 5'h0F,
    OP_SWAP_X_ACCUM       = 5'h10, OP_SWAP_Y_ACCUM       = 5'h11,
    OP_SWAP_MEM_ACCUM     = 5'h12, OP_SWAP_X_Y           = 5'h13,
    OP_WORD_ADD           = 5'h14, OP_WORD_SUBTRACT      = 5'h15,
    OP_WORD_COMPARE       = 5'h16, OP_WORD_DECREMENT     = 5'h17,
    OP_WORD_INCREMENT     = 5'h18, OP_WORD_LOAD_PAIR     = 5'h19,
    OP_WORD_STORE_PAIR    = 5'h1A
  } ctw_op_e;

  typedef enum logic [3:0] {
    AM_NONE = 4'h0, AM_IMM  = 4'h1, AM_DP  = 4'h2, AM_DPX  = 4'h3,
    AM_DPY  = 4'h4, AM_ABS  = 4'h5, AM_ABSY = 4'h6, AM_IDX = 4'h7,
    AM_IDY  = 4'h8, AM_XIND = 4'h9
  } ctw_mode_e;

  typedef struct packed {
    ctw_op_e    op;
    ctw_mode_e  mode;
    logic [3:0] cycles;
  } ctw_dec_s;

  typedef struct packed {
    logic n;
    logic v;
    logic h;
    logic z;
    logic c;
  } ctw_flags_s;

  typedef struct packed {
    logic [7:0] opcode;
    logic [7:0] opnd1;
    logic [7:0] opnd2;
  } ctw_instr_s;

  typedef struct packed {
    logic [15:0] addr;
    logic [7:0]  wdata;
    logic        we;
    logic        re;
  } ctw_mem_s;

  // ----------------------------------------------------------------
  // opcode table: class, addressing mode, total cycles
  // ----------------------------------------------------------------
  function automatic ctw_dec_s ctw_decode(input logic [7:0] opc);
    ctw_dec_s d;
    d = '{op: OP_NONE, mode: AM_NONE, cycles: CTW_CYC_ONE};
    case (opc)
      8'hC4: d = '{OP_LOAD_ACCUM, AM_IMM, 4'h2};
      8'hC5: d = '{OP_LOAD_ACCUM, AM_DP, 4'h3};
      8'hC6: d = '{OP_LOAD_ACCUM, AM_DPX, 4'h4};
      8'hC7: d = '{OP_LOAD_ACCUM, AM_ABS, 4'h4};
      8'hD5: d = '{OP_LOAD_ACCUM, AM_ABSY, 4'h5};
      8'hD6: d = '{OP_LOAD_ACCUM, AM_IDX, 4'h6};
      8'hD7: d = '{OP_LOAD_ACCUM, AM_IDY, 4'h6};
      8'hD4: d = '{OP_LOAD_ACCUM, AM_XIND, 4'h3};
      8'hDB: d = '{OP_LOAD_ACCUM_XI, AM_XIND, 4'h4};
      8'hE4: d = '{OP_LOAD_MEM_IMMEDIATE, AM_DP, 4'h5};
      8'h1E: d = '{OP_LOAD_INDEX_X, AM_IMM, 4'h2};
      8'hCC: d = '{OP_LOAD_INDEX_X, AM_DP, 4'h3};
      8'hCD: d = '{OP_LOAD_INDEX_X, AM_DPY, 4'h4};
      8'hDC: d = '{OP_LOAD_INDEX_X, AM_ABS, 4'h4};
      8'h3E: d = '{OP_LOAD_INDEX_Y, AM_IMM, 4'h2};
      8'hC9: d = '{OP_LOAD_INDEX_Y, AM_DP, 4'h3};
      8'hD9: d = '{OP_LOAD_INDEX_Y, AM_DPX, 4'h4};
      8'hD8: d = '{OP_LOAD_INDEX_Y, AM_ABS, 4'h4};
      8'hE5: d = '{OP_STORE_ACCUM, AM_DP, 4'h4};
      8'hE6: d = '{OP_STORE_ACCUM, AM_DPX, 4'h5};
      8'hE7: d = '{OP_STORE_ACCUM, AM_ABS, 4'h5};
      8'hF5: d = '{OP_STORE_ACCUM, AM_ABSY, 4'h6};
      8'hF6: d = '{OP_STORE_ACCUM, AM_IDX, 4'h7};
      8'hF7: d = '{OP_STORE_ACCUM, AM_IDY, 4'h7};
      8'hF4: d = '{OP_STORE_ACCUM, AM_XIND, 4'h4};
      8'hFB: d = '{OP_STORE_ACCUM_XI, AM_XIND, 4'h4};
      8'hEC: d = '{OP_STORE_INDEX_X, AM_DP, 4'h4};
      8'hED: d = '{OP_STORE_INDEX_X, AM_DPY, 4'h5};
      8'hFC: d = '{OP_STORE_INDEX_X, AM_ABS, 4'h5};
      8'hE9: d = '{OP_STORE_INDEX_Y, AM_DP, 4'h4};
      8'hF9: d = '{OP_STORE_INDEX_Y, AM_DPX, 4'h5};
      8'hF8: d = '{OP_STORE_INDEX_Y, AM_ABS, 4'h5};
      8'hE8: d = '{OP_COPY_ACCUM_TO_X, AM_NONE, 4'h2};
      8'h9F: d = '{OP_COPY_ACCUM_TO_Y, AM_NONE, 4'h2};
      8'hAE: d = '{OP_COPY_STACKPTR_TO_X, AM_NONE, 4'h2};
      8'hC8: d = '{OP_COPY_X_TO_ACCUM, AM_NONE, 4'h2};
      8'h8E: d = '{OP_COPY_X_TO_STACKPTR, AM_NONE, 4'h2};
      8'hBF: d = '{OP_COPY_Y_TO_ACCUM, AM_NONE, 4'h2};
      8'hEE: d = '{OP_SWAP_X_ACCUM, AM_NONE, 4'h4};
      8'hDE: d = '{OP_SWAP_Y_ACCUM, AM_NONE, 4'h4};
      8'hBC: d = '{OP_SWAP_MEM_ACCUM, AM_DP, 4'h5};
      8'hAD: d = '{OP_SWAP_MEM_ACCUM, AM_DPX, 4'h6};
      8'hBB: d = '{OP_SWAP_MEM_ACCUM, AM_XIND, 4'h5};
      8'hFE: d = '{OP_SWAP_X_Y, AM_NONE, 4'h4};
      8'h1D: d = '{OP_WORD_ADD, AM_DP, 4'h5};
      8'h3D: d = '{OP_WORD_SUBTRACT, AM_DP, 4'h5};
      8'h5D: d = '{OP_WORD_COMPARE, AM_DP, 4'h4};
      8'hBD: d = '{OP_WORD_DECREMENT, AM_DP, 4'h6};
      8'h9D: d = '{OP_WORD_INCREMENT, AM_DP, 4'h6};
      8'h7D: d = '{OP_WORD_LOAD_PAIR, AM_DP, 4'h5};
      8'hDD: d = '{OP_WORD_STORE_PAIR, AM_DP, 4'h5};
      default: d = '{op: OP_NONE, mode: AM_NONE, cycles: CTW_CYC_ONE};
    endcase
    return d;
  endfunction : ctw_decode

  function automatic ctw_flags_s ctw_set_nz(input ctw_flags_s f, input logic [7:0] v);
    ctw_flags_s r;
    r = f;
    r.n = v[7];
    r.z = (v == 8'h00);
    return r;
  endfunction : ctw_set_nz

  // next byte of a pair stays inside the same 256-byte page
  function automatic logic [15:0] ctw_next_addr(input logic [15:0] a);
    return {a[15:8], 8'(a[7:0] + 8'h01)};
  endfunction : ctw_next_addr

endpackage : ctw_pkg

/* File: verilog/ctw_word_alu.sv */
`timescale 1ns/10ps
module ctw_word_alu (
  // operation and operands
  input  wire ctw_pkg::ctw_op_e    op,
  input  wire logic [15:0]         ya,
  input  wire logic [15:0]         mem_word,
  input  wire ctw_pkg::ctw_flags_s flg_in,
  // result
  output ctw_pkg::ctw_flags_s      flg_out,
  output logic [15:0]              result
);
  import ctw_pkg::*;

  logic [16:0] sum;
  logic [12:0] half;

  always_comb begin
    sum     = {1'b0, ya};
    half    = 13'h0000;
    flg_out = flg_in;
    case (op)
      OP_WORD_ADD: begin
        // incoming carry is ignored
        sum       = {1'b0, ya} + {1'b0, mem_word};
        half      = {1'b0, ya[11:0]} + {1'b0, mem_word[11:0]};
        flg_out.c = sum[16];
        flg_out.h = half[12];
        flg_out.v = (ya[15] == mem_word[15]) && (sum[15] != ya[15]);
      end
      OP_WORD_SUBTRACT, OP_WORD_COMPARE: begin
        // carry set means no borrow
        sum       = {1'b0, ya} - {1'b0, mem_word};
        half      = {1'b0, ya[11:0]} - {1'b0, mem_word[11:0]};
        flg_out.c = ~sum[16];
        if (op == OP_WORD_SUBTRACT) begin
          flg_out.h = ~half[12];
          flg_out.v = (ya[15] != mem_word[15]) && (sum[15] != ya[15]);
        end
      end
      OP_WORD_INCREMENT: sum = {1'b0, mem_word} + 17'h00001;
      OP_WORD_DECREMENT: sum = {1'b0, mem_word} - 17'h00001;
      default: sum = {1'b0, ya};
    endcase
    result    = sum[15:0];
    flg_out.n = sum[15];
    flg_out.z = (sum[15:0] == 16'h0000);
  end

endmodule : ctw_word_alu

/* File: verilog/ctw_core.sv */
// Behaviour
// - auto-increment load reads byte at X into A, then X plus one; 4 cycles
// - immediate-to-memory load writes operand byte to direct page; flags kept
// - accumulator stores write A to memory in each mode; flags kept
// - auto-increment store writes A at X, then X plus one; 4 cycles
// - X stores write X to memory in three modes; flags kept
// - Y stores write Y to memory in three modes; flags kept
// - copy A into X in 2 cycles; N and Z follow value
// - copy A into Y in 2 cycles; N and Z follow value
// - copy stack pointer into X in 2 cycles; N and Z follow value
// - copy X into A in 2 cycles; N and Z follow value
// - load stack pointer from X in 2 cycles; N and Z follow value
// - copy Y into A in 2 cycles; N and Z follow value
// - swap X and A in 4 cycles, flags untouched
// - swap Y and A in 4 cycles, flags untouched
// - swap memory byte with A in three modes; N and Z follow new A
// - swap X and Y in 4 cycles, flags untouched
// - add direct-page word to Y:A without carry; N V H Z C updated
// - subtract direct-page word from Y:A without carry; N V H Z C updated
// - compare Y:A with direct-page word; N Z C only, nothing written
// - decrement direct-page word, write back, N and Z from result; 6 cycles
// - increment direct-page word, write back, N and Z from result; 6 cycles
// - write A to dp and Y to dp+1; flags kept
`timescale 1ns/10ps
module ctw_core (
  // clock and reset
  input  wire logic                clk_sys,
  input  wire logic                reset,
  // instruction from fetch
  input  wire logic                instr_valid,
  input  wire ctw_pkg::ctw_instr_s instr,
  input  wire logic [7:0]          dp_page,
  output logic                     instr_ready,
  output logic                     done,
  // data memory bus
  input  wire logic [7:0]          mem_rdata,
  output ctw_pkg::ctw_mem_s        mem,
  // architectural state
  output logic [7:0]               acc,
  output logic [7:0]               idx_x,
  output logic [7:0]               idx_y,
  output logic [7:0]               stack_ptr,
  output ctw_pkg::ctw_flags_s      flags
);
  import ctw_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE    = 3'b000,
    ST_PTR_HI  = 3'b001,
    ST_PTR_END = 3'b010,
    ST_RD_HI   = 3'b011,
    ST_TAKE    = 3'b100,
    ST_WR_HI   = 3'b101,
    ST_WAIT    = 3'b110
  } ctw_state_e;

  ctw_state_e  state_q,  state_d;
  logic [3:0]  rem_q,    rem_d;
  ctw_dec_s    dec_q,    dec_d;
  ctw_instr_s  ins_q,    ins_d;
  logic [15:0] ea_q,     ea_d;
  logic [7:0]  lo_q,     lo_d;
  logic [7:0]  hi_q,     hi_d;
  logic [7:0]  acc_q,    acc_d;
  logic [7:0]  x_q,      x_d;
  logic [7:0]  y_q,      y_d;
  logic [7:0]  sp_q,     sp_d;
  ctw_flags_s  flg_q,    flg_d;
  ctw_mem_s    mem_q,    mem_d;
  logic        ready_q;
  logic        done_q,   done_d;
  ctw_dec_s    dec_in;
  logic        launch;
  logic [15:0] launch_addr;
  ctw_flags_s  alu_flg;
  logic [15:0] alu_res;

  assign dec_in = ctw_decode(instr.opcode);

  // first address touched: the operand itself, or the pointer for indirect modes
  function automatic logic [15:0] ctw_first_addr(input ctw_mode_e m, input ctw_instr_s i,
                                                 input logic [7:0] x, input logic [7:0] y,
                                                 input logic [7:0] pg);
    logic [15:0] a;
    a = {pg, i.opnd1};
    case (m)
      AM_DPX, AM_IDX: a = {pg, 8'(i.opnd1 + x)};
      AM_DPY:         a = {pg, 8'(i.opnd1 + y)};
      AM_ABS:         a = {i.opnd2, i.opnd1};
      AM_ABSY:        a = {i.opnd2, i.opnd1} + {8'h00, y};
      AM_XIND:        a = {pg, x};
      default:        a = {pg, i.opnd1};
    endcase
    return a;
  endfunction : ctw_first_addr

  // ----------------------------------------------------------------
  // 16-bit arithmetic on the Y:A pair and memory words
  // ----------------------------------------------------------------
  ctw_word_alu u_word_alu (
    .op       (dec_q.op),
    .ya       ({y_q, acc_q}),
    .mem_word ({mem_rdata, lo_q}),
    .flg_in   (flg_q),
    .flg_out  (alu_flg),
    .result   (alu_res)
  );

  // ----------------------------------------------------------------
  // sequencing and execution
  // ----------------------------------------------------------------
  always_comb begin
    state_d     = state_q;
    rem_d       = rem_q;
    dec_d       = dec_q;
    ins_d       = ins_q;
    ea_d        = ea_q;
    lo_d        = lo_q;
    hi_d        = hi_q;
    acc_d       = acc_q;
    x_d         = x_q;
    y_d         = y_q;
    sp_d        = sp_q;
    flg_d       = flg_q;
    done_d      = 1'b0;
    mem_d       = '{addr: mem_q.addr, wdata: mem_q.wdata, we: 1'b0, re: 1'b0};
    launch      = 1'b0;
    launch_addr = ea_q;
    if (rem_q > CTW_REM_RST) begin
      rem_d = 4'(rem_q - CTW_REM_END);
    end
    case (state_q)
      ST_IDLE: begin
        // unknown opcodes belong to other units and are not taken here
        if (instr_valid && dec_in.op != OP_NONE) begin
          dec_d   = dec_in;
          ins_d   = instr;
          rem_d   = 4'(dec_in.cycles - CTW_CYC_ONE);
          ea_d    = ctw_first_addr(dec_in.mode, instr, x_q, y_q, dp_page);
          state_d = ST_WAIT;
          case (dec_in.mode)
            AM_NONE, AM_IMM: begin
              case (dec_in.op)
                OP_LOAD_ACCUM: begin
                  acc_d = instr.opnd1;
                  flg_d = ctw_set_nz(flg_q, instr.opnd1);
                end
                OP_LOAD_INDEX_X: begin
                  x_d   = instr.opnd1;
                  flg_d = ctw_set_nz(flg_q, instr.opnd1);
                end
                OP_LOAD_INDEX_Y: begin
                  y_d   = instr.opnd1;
                  flg_d = ctw_set_nz(flg_q, instr.opnd1);
                end
                OP_COPY_ACCUM_TO_X: begin
                  x_d   = acc_q;
                  flg_d = ctw_set_nz(flg_q, acc_q);
                end
                OP_COPY_ACCUM_TO_Y: begin
                  y_d   = acc_q;
                  flg_d = ctw_set_nz(flg_q, acc_q);
                end
                OP_COPY_STACKPTR_TO_X: begin
                  x_d   = sp_q;
                  flg_d = ctw_set_nz(flg_q, sp_q);
                end
                OP_COPY_X_TO_ACCUM: begin
                  acc_d = x_q;
                  flg_d = ctw_set_nz(flg_q, x_q);
                end
                OP_COPY_X_TO_STACKPTR: begin
                  sp_d  = x_q;
                  flg_d = ctw_set_nz(flg_q, x_q);
                end
                OP_COPY_Y_TO_ACCUM: begin
                  acc_d = y_q;
                  flg_d = ctw_set_nz(flg_q, y_q);
                end
                OP_SWAP_X_ACCUM: begin
                  acc_d = x_q;
                  x_d   = acc_q;
                end
                OP_SWAP_Y_ACCUM: begin
                  acc_d = y_q;
                  y_d   = acc_q;
                end
                OP_SWAP_X_Y: begin
                  x_d = y_q;
                  y_d = x_q;
                end
                default: state_d = ST_WAIT;
              endcase
            end
            AM_IDX, AM_IDY: begin
              mem_d.addr = ea_d;
              mem_d.re   = 1'b1;
              state_d    = ST_PTR_HI;
            end
            default: begin
              launch      = 1'b1;
              launch_addr = ea_d;
            end
          endcase
          if (dec_in.op == OP_LOAD_ACCUM_XI || dec_in.op == OP_STORE_ACCUM_XI) begin
            // the access already latched the old X, so the bump cannot disturb it
            x_d = 8'(x_q + 8'h01);
          end
        end
      end
      ST_PTR_HI: begin
        lo_d       = mem_rdata;
        mem_d.addr = ctw_next_addr(ea_q);
        mem_d.re   = 1'b1;
        state_d    = ST_PTR_END;
      end
      ST_PTR_END: begin
        launch      = 1'b1;
        launch_addr = {mem_rdata, lo_q};
        if (dec_q.mode == AM_IDY) begin
          launch_addr = {mem_rdata, lo_q} + {8'h00, y_q};
        end
      end
      ST_RD_HI: begin
        lo_d       = mem_rdata;
        mem_d.addr = ctw_next_addr(ea_q);
        mem_d.re   = 1'b1;
        state_d    = ST_TAKE;
      end
      ST_TAKE: begin
        state_d = ST_WAIT;
        case (dec_q.op)
          OP_LOAD_ACCUM, OP_LOAD_ACCUM_XI: begin
            acc_d = mem_rdata;
            flg_d = ctw_set_nz(flg_q, mem_rdata);
          end
          OP_LOAD_INDEX_X: begin
            x_d   = mem_rdata;
            flg_d = ctw_set_nz(flg_q, mem_rdata);
          end
          OP_LOAD_INDEX_Y: begin
            y_d   = mem_rdata;
            flg_d = ctw_set_nz(flg_q, mem_rdata);
          end
          OP_SWAP_MEM_ACCUM: begin
            acc_d       = mem_rdata;
            flg_d       = ctw_set_nz(flg_q, mem_rdata);
            mem_d.addr  = ea_q;
            mem_d.wdata = acc_q;
            mem_d.we    = 1'b1;
          end
          OP_WORD_ADD, OP_WORD_SUBTRACT: begin
            {y_d, acc_d} = alu_res;
            flg_d        = alu_flg;
          end
          OP_WORD_COMPARE: flg_d = alu_flg;
          OP_WORD_INCREMENT, OP_WORD_DECREMENT: begin
            flg_d.n     = alu_flg.n;
            flg_d.z     = alu_flg.z;
            hi_d        = alu_res[15:8];
            mem_d.addr  = ea_q;
            mem_d.wdata = alu_res[7:0];
            mem_d.we    = 1'b1;
            state_d     = ST_WR_HI;
          end
          OP_WORD_LOAD_PAIR: begin
            acc_d   = lo_q;
            y_d     = mem_rdata;
            flg_d.n = mem_rdata[7];
            flg_d.z = ({mem_rdata, lo_q} == 16'h0000);
          end
          default: state_d = ST_WAIT;
        endcase
      end
      ST_WR_HI: begin
        mem_d.addr  = ctw_next_addr(ea_q);
        mem_d.wdata = hi_q;
        mem_d.we    = 1'b1;
        state_d     = ST_WAIT;
      end
      default: state_d = state_q;
    endcase
    // operand address known: stores and the immediate-to-memory load write at once, the rest read
    if (launch) begin
      ea_d       = launch_addr;
      mem_d.addr = launch_addr;
      state_d    = ST_TAKE;
      case (dec_d.op)
        OP_STORE_ACCUM, OP_STORE_ACCUM_XI: begin
          mem_d.wdata = acc_q;
          mem_d.we    = 1'b1;
          state_d     = ST_WAIT;
        end
        OP_STORE_INDEX_X: begin
          mem_d.wdata = x_q;
          mem_d.we    = 1'b1;
          state_d     = ST_WAIT;
        end
        OP_STORE_INDEX_Y: begin
          mem_d.wdata = y_q;
          mem_d.we    = 1'b1;
          state_d     = ST_WAIT;
        end
        OP_LOAD_MEM_IMMEDIATE: begin
          mem_d.wdata = ins_d.opnd2;
          mem_d.we    = 1'b1;
          state_d     = ST_WAIT;
        end
        OP_WORD_STORE_PAIR: begin
          mem_d.wdata = acc_q;
          mem_d.we    = 1'b1;
          hi_d        = y_q;
          state_d     = ST_WR_HI;
        end
        OP_WORD_ADD, OP_WORD_SUBTRACT, OP_WORD_COMPARE,
        OP_WORD_INCREMENT, OP_WORD_DECREMENT, OP_WORD_LOAD_PAIR: begin
          mem_d.re = 1'b1;
          state_d  = ST_RD_HI;
        end
        default: mem_d.re = 1'b1;
      endcase
    end
    // the cycle budget, not the micro-sequence, decides when the next opcode is taken
    if (state_q != ST_IDLE && rem_q == CTW_REM_END) begin
      state_d = ST_IDLE;
      done_d  = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // flip-flops
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      state_q <= ST_IDLE;
      rem_q   <= CTW_REM_RST;
      ready_q <= 1'b1;
      done_q  <= 1'b0;
    end else begin
      state_q <= state_d;
      rem_q   <= rem_d;
      ready_q <= (state_d == ST_IDLE);
      done_q  <= done_d;
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      dec_q <= '{op: OP_NONE, mode: AM_NONE, cycles: CTW_CYC_ONE};
      ins_q <= '0;
      ea_q  <= '0;
      lo_q  <= '0;
      hi_q  <= '0;
    end else begin
      dec_q <= dec_d;
      ins_q <= ins_d;
      ea_q  <= ea_d;
      lo_q  <= lo_d;
      hi_q  <= hi_d;
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      acc_q <= CTW_ACC_RST;
      x_q   <= CTW_X_RST;
      y_q   <= CTW_Y_RST;
      sp_q  <= CTW_SP_RST;
      flg_q <= '0;
    end else begin
      acc_q <= acc_d;
      x_q   <= x_d;
      y_q   <= y_d;
      sp_q  <= sp_d;
      flg_q <= flg_d;
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      mem_q <= '0;
    end else begin
      mem_q <= mem_d;
    end
  end

  assign instr_ready = ready_q;
  assign done        = done_q;
  assign mem         = mem_q;
  assign acc         = acc_q;
  assign idx_x       = x_q;
  assign idx_y       = y_q;
  assign stack_ptr   = sp_q;
  assign flags       = flg_q;

endmodule : ctw_core

/* File: testbench/ctw_mem_model.sv */
`timescale 1ns/10ps
module ctw_mem_model (
  // clock
  input wire logic              clk_sys,
  // bus from the core
  input wire ctw_pkg::ctw_mem_s mem,
  output logic [7:0]            mem_rdata
);
  import ctw_pkg::*;
  logic [7:0] ram [0:65535];
  initial begin
    foreach (ram[i]) ram[i] = 8'h00;
  end
  // read-through; with no read strobe the inverse shows so a stale sample never matches
  assign mem_rdata = mem.re ? ram[mem.addr] : ~ram[mem.addr];
  always @(posedge clk_sys) begin
    if (mem.we) begin
      ram[mem.addr] <= mem.wdata;
    end
  end
endmodule : ctw_mem_model

/* File: testbench/ctw_core_checker.sv */
`timescale 1ns/10ps
module ctw_core_checker (
  // clock and reset
  input wire logic                clk_sys,
  input wire logic                reset,
  // instruction side
  input wire logic                instr_valid,
  input wire ctw_pkg::ctw_instr_s instr,
  input wire logic [7:0]          dp_page,
  input wire logic                instr_ready,
  input wire logic                done,
  // memory side
  input wire ctw_pkg::ctw_mem_s   mem,
  // state
  input wire logic [7:0]          acc,
  input wire logic [7:0]          idx_x,
  input wire logic [7:0]          idx_y,
  input wire ctw_pkg::ctw_flags_s flags
);
  import ctw_pkg::*;
  wire       go = instr_ready && instr_valid;
  wire [7:0] oc = instr.opcode;
  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (reset);
  chk_copy_a_x: assert property (go && oc == 8'hE8 |=> idx_x == $past(acc) ##1 done)
    else $error("copy a to x wrong");
  chk_copy_a_y: assert property (go && oc == 8'h9F |=> flags.z == ($past(acc) == 8'h00))
    else $error("copy a to y flag wrong");
  chk_copy_x_a: assert property (go && oc == 8'hC8 |=> acc == $past(idx_x))
    else $error("copy x to a wrong");
  chk_swap_x_y: assert property (go && oc == 8'hFE |=> idx_x == $past(idx_y)
    && idx_y == $past(idx_x) ##0 $stable(flags) [*3] ##1 done) else $error("swap x y wrong");
  chk_store_acc: assert property (go && oc == 8'hE5 |=> mem.we && mem.wdata == $past(acc)
    && mem.addr == {$past(dp_page), $past(instr.opnd1)}) else $error("store a wrong");
  chk_autoinc_load: assert property (go && oc == 8'hDB |=> mem.re
    && mem.addr[7:0] == $past(idx_x) && idx_x == 8'($past(idx_x) + 8'h01) ##3 done)
    else $error("auto-increment load wrong");
  chk_pair_store: assert property (go && oc == 8'hDD |=> mem.we && mem.wdata == $past(acc)
    ##1 mem.we && mem.wdata == idx_y && mem.addr[7:0] == 8'($past(instr.opnd1, 2) + 8'h01))
    else $error("pair store wrong");
  chk_imm_store: assert property (go && oc == 8'hE4 |=> mem.we
    && mem.wdata == $past(instr.opnd2) ##0 !instr_ready [*4] ##1 (done && instr_ready))
    else $error("immediate store wrong");
endmodule : ctw_core_checker

bind ctw_core ctw_core_checker u_chk (.clk_sys, .reset, .instr_valid, .instr, .dp_page,
  .instr_ready, .done, .mem, .acc, .idx_x, .idx_y, .flags);

/* File: testbench/ctw_core_tb_top.sv */
`timescale 1ns/10ps
module ctw_core_tb_top;
  import ctw_pkg::*;
  logic       clk_sys = 1'b0;
  logic       reset;
  logic       instr_valid;
  ctw_instr_s instr;
  logic [7:0] dp_page;
  logic       instr_ready;
  logic       done;
  logic [7:0] mem_rdata;
  ctw_mem_s   mem;
  logic [7:0] acc;
  logic [7:0] idx_x;
  logic [7:0] idx_y;
  logic [7:0] stack_ptr;
  ctw_flags_s flags;
  int         fail_count = 0;
  int         tests_run = 0;
  // opcode and cycle count, three hex digits each
  localparam string OPS = {"C42C53C64C74D55D66D76D43DB4E451E2CC3CD4DC43E2C93D94D84E54E65E75F56",
    "F67F77F44FB4EC4ED5FC5E94F95F85E829F2AE2C828E2BF2EE4DE4BC5AD6BB5FE41D53D55D4BD69D67D5DD5"};

  ctw_core dut (.clk_sys, .reset, .instr_valid, .instr, .dp_page, .instr_ready, .done,
    .mem_rdata, .mem, .acc, .idx_x, .idx_y, .stack_ptr, .flags);
  ctw_mem_model mdl (.clk_sys, .mem, .mem_rdata);
  always #10 clk_sys = ~clk_sys;

  // ------
  // shared tasks
  // ------
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    tests_run++;
    if (g !== e) begin
      fail_count++;
      $display("unexpected at %0t: got %h exp %h", $time, g, e);
    end
  endtask : chk

  task automatic run(input logic [23:0] ins, input int cy);
    int n;
    @(posedge clk_sys);
    instr_valid <= 1'b1;
    instr       <= ins;
    @(posedge clk_sys);
    instr_valid <= 1'b0;
    #1;
    n = 1;
    while (done !== 1'b1 && n < 20) begin
      @(posedge clk_sys);
      #1;
      n++;
    end
    chk(16'(n), 16'(cy));
  endtask : run

  // expected state packs a, x, y and the flags byte
  task automatic op(input logic [23:0] ins, input int cy, input logic [31:0] e);
    run(ins, cy);
    chk({acc, idx_x}, e[31:16]);
    chk({idx_y, 3'b000, flags}, e[15:0]);
  endtask : op

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : final_report

  // ------
  // scenarios
  // ------
  task automatic t_move();
    op(24'hC48000, 2, 32'h80000010);
    op(24'hE80000, 2, 32'h80800010);
    op(24'h8E0000, 2, 32'h80800010);
    chk(16'(stack_ptr), 16'h0080);
    op(24'h1E0000, 2, 32'h80000002);
    op(24'hAE0000, 2, 32'h80800010);
    op(24'hC40000, 2, 32'h00800002);
    op(24'hC80000, 2, 32'h80800010);
    op(24'h3E7F00, 2, 32'h80807F00);
    op(24'hBF0000, 2, 32'h7F807F00);
    op(24'hC40000, 2, 32'h00807F02);
    op(24'h9F0000, 2, 32'h00800002);
    $display("test move done");
  endtask : t_move

  task automatic t_swap();
    op(24'h3E5A00, 2, 32'h00805A00);
    op(24'hEE0000, 4, 32'h80005A00);
    op(24'hDE0000, 4, 32'h5A008000);
    op(24'hFE0000, 4, 32'h5A800000);
    $display("test swap done");
  endtask : t_swap

  task automatic t_mem();
    mdl.ram[16'h0233] = 8'hFF;
    mdl.ram[16'h0200] = 8'h99;
    op(24'hBC2000, 5, 32'h00800002);
    chk(16'(mdl.ram[16'h0220]), 16'h005A);
    op(24'hC4C300, 2, 32'hC3800010);
    op(24'hE53000, 4, 32'hC3800010);
    op(24'hE4313C, 5, 32'hC3800010);
    op(24'hE93300, 4, 32'hC3800010);
    chk({mdl.ram[16'h0230], mdl.ram[16'h0231]}, 16'hC33C);
    chk(16'(mdl.ram[16'h0233]), 16'h0000);
    op(24'hCC3100, 3, 32'hC33C0000);
    op(24'hEC3200, 4, 32'hC33C0000);
    chk(16'(mdl.ram[16'h0232]), 16'h003C);
    op(24'h1EFF00, 2, 32'hC3FF0010);
    op(24'hFB0000, 4, 32'hC3000010);
    chk(16'(mdl.ram[16'h02FF]), 16'h00C3);
    op(24'hDB0000, 4, 32'h99010010);
    $display("test memory done");
  endtask : t_mem

  task automatic t_word();
    mdl.ram[16'h0240] = 8'hFF;
    mdl.ram[16'h0241] = 8'h7F;
    mdl.ram[16'h0242] = 8'h01;
    mdl.ram[16'h0244] = 8'hFF;
    mdl.ram[16'h0246] = 8'hFF;
    mdl.ram[16'h0247] = 8'hFF;
    op(24'h7D4000, 5, 32'hFF017F00);
    op(24'h3D4200, 5, 32'hFE017F05);
    op(24'h1D4200, 5, 32'hFF017F00);
    op(24'h1D4200, 5, 32'h0001801C);
    op(24'h5D4000, 4, 32'h0001800D);
    op(24'hDD4400, 5, 32'h0001800D);
    chk({mdl.ram[16'h0245], mdl.ram[16'h0244]}, 16'h8000);
    op(24'h9D4600, 6, 32'h0001800F);
    chk({mdl.ram[16'h0247], mdl.ram[16'h0246]}, 16'h0000);
    op(24'hBD4600, 6, 32'h0001801D);
    chk({mdl.ram[16'h0247], mdl.ram[16'h0246]}, 16'hFFFF);
    $display("test word done");
  endtask : t_word

  task automatic t_cycles();
    logic [11:0] v;
    for (int i = 0; i < 51; i++) begin
      void'($sscanf(OPS.substr(3 * i, 3 * i + 2), "%h", v));
      run({v[11:4], 16'h0000}, int'(v[3:0]));
    end
    $display("test cycles done");
  endtask : t_cycles

  initial begin
    reset       = 1'b1;
    instr_valid = 1'b0;
    instr       = '0;
    dp_page     = 8'h02;
    repeat (20) @(posedge clk_sys);
    reset <= 1'b0;
    t_move();
    t_swap();
    t_mem();
    t_word();
    t_cycles();
    final_report();
  end

  initial begin
    repeat (3000) @(posedge clk_sys);
    fail_count++;
    final_report();
  end
endmodule : ctw_core_tb_top
